// ==== hw/dcc_top.sv ====
// What this block does
// - fetch takes at most four per cycle
// - holding queue caps at twelve, fetch stalls
// - dispatch only from slots zero to two
// - at most three dispatched per cycle
// - float one, vector two, general three
// - dispatch needs a free retirement entry
// - decode fully before queueing anything
// - sixteen renames per class, wait when empty
// - retire when older done, finished, no exception
// - track all dispatched, retire in order
// - at most three retired per cycle
// - mispredicted branch flushes all younger work
// - at most three open branches
// - sixteen instructions in flight at most
// - one stage per cycle, single cycle flow
// - exceptions precise, older retire, younger dropped
`timescale 1ns/1ns
module dcc_top #(
  parameter  int HQ_DEPTH  = dcc_pkg::HQ_DEPTH,  // holding queue slots
  parameter  int CQ_DEPTH  = dcc_pkg::CQ_DEPTH,  // retirement entries
  parameter  int REN_DEPTH = dcc_pkg::REN_DEPTH, // renames per pool
  parameter  int BR_MAX    = dcc_pkg::BR_MAX,    // open branches
  localparam int FW        = dcc_pkg::FETCH_W,
  localparam int DW        = dcc_pkg::DISP_W,
  localparam int RTW       = dcc_pkg::RET_W,
  localparam int NFIN      = dcc_pkg::FIN_W,
  localparam int NP        = dcc_pkg::REN_POOLS,
  localparam int WW        = dcc_pkg::WORD_W,
  localparam int CW        = $clog2(CQ_DEPTH),
  localparam int HW        = $clog2(HQ_DEPTH + 1),
  localparam int RW        = $clog2(REN_DEPTH + 1),
  localparam int NRW       = $clog2(RTW + 1)
) (
  input  wire logic                      ref_clk_i,     // core clock
  input  wire logic                      rstn_i,        // async reset
  input  wire logic [2:0]                fetch_cnt_i,   // words offered
  input  wire logic [FW-1:0][WW-1:0]     fetch_word_i,  // word 0 oldest
  output logic                           fetch_ready_o, // room for four
  input  wire logic [1:0]                fiq_room_i,    // float room
  input  wire logic [1:0]                viq_room_i,    // vector room
  input  wire logic [1:0]                giq_room_i,    // general room
  output logic [DW-1:0]                  disp_valid_o,  // per slot
  output dcc_pkg::dcc_ins_s [DW-1:0]     disp_ins_o,    // decoded ins
  output logic [DW-1:0][CW-1:0]          disp_idx_o,    // entry index
  input  wire logic [NFIN-1:0]           fin_valid_i,   // finish report
  input  wire logic [NFIN-1:0][CW-1:0]   fin_idx_i,     // finished entry
  input  wire logic [NFIN-1:0]           fin_exc_i,     // raised fault
  input  wire logic                      br_valid_i,    // branch resolved
  input  wire logic [CW-1:0]             br_idx_i,      // branch entry
  input  wire logic                      br_mispred_i,  // wrong guess
  output logic [NRW-1:0]                 retire_cnt_o,  // retired count
  output logic                           exc_o,         // precise fault
  output logic [CW-1:0]                  exc_idx_o,     // faulting entry
  output logic                           flush_o,       // discard younger
  output logic [CW-1:0]                  flush_idx_o    // last kept branch, or dropped fault
);

  // ----------------------------------------------------------------
  // configuration check
  // ----------------------------------------------------------------
  if (HQ_DEPTH < FW + DW || (1 << CW) != CQ_DEPTH ||
      CQ_DEPTH < RTW || REN_DEPTH < 1 || BR_MAX < 1) begin : g_bad_cfg
    $error("dcc_top: unsupported queue sizes");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // distance of an entry from the queue head
  function automatic logic [CW-1:0] age_of(input logic [CW-1:0] i,
                                           input logic [CW-1:0] h);
    age_of = i - h;
  endfunction

  // entry lies inside the occupied part of the ring
  function automatic logic in_q(input logic [CW-1:0] i,
                                input logic [CW-1:0] h,
                                input logic [CW:0]   c);
    in_q = {1'b0, age_of(i, h)} < c;
  endfunction

  // rename pool for a destination class
  function automatic logic [1:0] pool_of(input logic [1:0] d);
    pool_of = d - 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dcc_pkg::dcc_ins_s           hq_r  [HQ_DEPTH];
  dcc_pkg::dcc_ins_s           hq_nxt[HQ_DEPTH];
  logic [HW-1:0]               hq_cnt_r;
  logic [HW-1:0]               hq_cnt_nxt;
  dcc_pkg::dcc_cqe_s           cq_r  [CQ_DEPTH];
  logic [CW-1:0]               head_r;
  logic [CW-1:0]               tail_r;
  logic [CW:0]                 cq_cnt_r;
  logic [NP-1:0][RW-1:0]       ren_free_r;
  dcc_pkg::dcc_ins_s [FW-1:0]  dec;
  logic [DW-1:0]               disp_go;
  logic [RTW-1:0]              ret_go;
  logic                        exc_take;
  logic                        mispred;
  logic                        flush_any;
  int                          n_disp;
  int                          n_ret;
  int                          n_acc;
  int                          n_keep;
  int                          br_open;
  int                          use_f;
  int                          use_v;
  int                          use_g;
  int                          use_b;
  int                          alloc[NP];
  int                          rel  [NP];

  // ----------------------------------------------------------------
  // decode ahead of the holding queue
  // ----------------------------------------------------------------
  // every word is decoded before it may enter a queue
  for (genvar g = 0; g < FW; g++) begin : g_dec
    dcc_decode u_dec (
      .word_i (fetch_word_i[g]),
      .ins_o  (dec[g])
    );
  end

  // ----------------------------------------------------------------
  // branch window and flush decision
  // ----------------------------------------------------------------
  // count unresolved branches held in the ring
  always_comb begin
    br_open = 0;
    for (int i = 0; i < CQ_DEPTH; i++) begin
      if (in_q(CW'(i), head_r, cq_cnt_r) && cq_r[i].br && !cq_r[i].done)
        br_open++;
    end
  end

  // a fault at the head outranks a branch flush
  assign exc_take = (cq_cnt_r != '0) && cq_r[head_r].done &&
                    cq_r[head_r].exc;
  assign mispred  = br_valid_i && br_mispred_i && !exc_take &&
                    in_q(br_idx_i, head_r, cq_cnt_r);
  assign flush_any = exc_take || mispred;

  // ----------------------------------------------------------------
  // dispatch selection
  // ----------------------------------------------------------------
  // in order from slot zero; the first blocked slot stops the rest
  always_comb begin
    logic ok;
    logic fit;
    dcc_pkg::dcc_ins_s ins;
    ok      = !flush_any;
    fit     = 1'b0;
    ins     = hq_r[0];
    disp_go = '0;
    n_disp  = 0;
    use_f   = 0;
    use_v   = 0;
    use_g   = 0;
    use_b   = 0;
    for (int p = 0; p < NP; p++)
      alloc[p] = 0;
    for (int k = 0; k < DW; k++) begin
      ins = hq_r[k];
      fit = ok && (k < int'(hq_cnt_r));
      // a retirement entry is needed even without an issue slot
      if (int'(cq_cnt_r) + n_disp >= CQ_DEPTH)
        fit = 1'b0;
      case (ins.unit)
        dcc_pkg::U_FLT:
          if (use_f >= dcc_pkg::FIQ_MAX || use_f >= int'(fiq_room_i))
            fit = 1'b0;
        dcc_pkg::U_VEC:
          if (use_v >= dcc_pkg::VIQ_MAX || use_v >= int'(viq_room_i))
            fit = 1'b0;
        dcc_pkg::U_GEN:
          if (use_g >= dcc_pkg::GIQ_MAX || use_g >= int'(giq_room_i))
            fit = 1'b0;
        default: ;
      endcase
      if (ins.dest != dcc_pkg::D_NONE &&
          alloc[pool_of(ins.dest)] >=
          int'(ren_free_r[pool_of(ins.dest)]))
        fit = 1'b0;
      if (ins.br && br_open + use_b >= BR_MAX)
        fit = 1'b0;
      if (fit) begin
        disp_go[k] = 1'b1;
        n_disp++;
        if (ins.unit == dcc_pkg::U_FLT) use_f++;
        if (ins.unit == dcc_pkg::U_VEC) use_v++;
        if (ins.unit == dcc_pkg::U_GEN) use_g++;
        if (ins.br) use_b++;
        if (ins.dest != dcc_pkg::D_NONE)
          alloc[pool_of(ins.dest)]++;
      end
      ok = fit;
    end
  end

  // ----------------------------------------------------------------
  // retirement selection
  // ----------------------------------------------------------------
  // consecutive finished entries from the head, stopping at a fault
  always_comb begin
    logic ok;
    logic [CW-1:0] idx;
    ok     = 1'b1;
    idx    = head_r;
    ret_go = '0;
    n_ret  = 0;
    for (int p = 0; p < NP; p++)
      rel[p] = 0;
    for (int k = 0; k < RTW; k++) begin
      idx = head_r + CW'(k);
      if (ok && k < int'(cq_cnt_r) && cq_r[idx].done &&
          !cq_r[idx].exc) begin
        ret_go[k] = 1'b1;
        n_ret++;
        if (cq_r[idx].dest != dcc_pkg::D_NONE)
          rel[pool_of(cq_r[idx].dest)]++;
      end else begin
        ok = 1'b0;
      end
    end
    // younger than a wrong branch give back their renames
    if (mispred) begin
      for (int i = 0; i < CQ_DEPTH; i++) begin
        if (in_q(CW'(i), head_r, cq_cnt_r) &&
            age_of(CW'(i), head_r) > age_of(br_idx_i, head_r) &&
            cq_r[i].dest != dcc_pkg::D_NONE)
          rel[pool_of(cq_r[i].dest)]++;
      end
    end
  end

  // ----------------------------------------------------------------
  // holding queue
  // ----------------------------------------------------------------
  // shift out dispatched slots, append accepted fetch behind the rest
  always_comb begin
    n_acc = 0;
    if (fetch_ready_o && !flush_any && !flush_o)
      n_acc = (int'(fetch_cnt_i) > FW) ? FW : int'(fetch_cnt_i);
    n_keep = int'(hq_cnt_r) - n_disp;
    for (int i = 0; i < HQ_DEPTH; i++) begin
      hq_nxt[i] = hq_r[i];
      if (i < n_keep)
        hq_nxt[i] = hq_r[i + n_disp];
      else if (i - n_keep < n_acc)
        hq_nxt[i] = dec[i - n_keep];
    end
    hq_cnt_nxt = flush_any ? '0 : HW'(n_keep + n_acc);
  end

  // holding queue storage advances once per cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hq_cnt_r <= '0;
      for (int i = 0; i < HQ_DEPTH; i++)
        hq_r[i] <= '0;
    end else begin
      hq_cnt_r <= hq_cnt_nxt;
      for (int i = 0; i < HQ_DEPTH; i++)
        hq_r[i] <= hq_nxt[i];
    end
  end

  // fetch may deliver only when a whole group still fits
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_ready_o <= 1'b0;
    end else begin
      fetch_ready_o <= int'(hq_cnt_nxt) <= HQ_DEPTH - FW;
    end
  end

  // ----------------------------------------------------------------
  // retirement queue entries
  // ----------------------------------------------------------------
  // allocate at the tail, mark finish and branch resolution
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < CQ_DEPTH; i++)
        cq_r[i] <= '0;
    end else begin
      for (int k = 0; k < DW; k++) begin
        if (disp_go[k]) begin
          // non-branch entries without an issue slot are finished at once
          cq_r[tail_r + CW'(k)].done <= hq_r[k].unit == dcc_pkg::U_NONE &&
                                        !hq_r[k].br;
          cq_r[tail_r + CW'(k)].exc  <= 1'b0;
          cq_r[tail_r + CW'(k)].br   <= hq_r[k].br;
          cq_r[tail_r + CW'(k)].dest <= hq_r[k].dest;
        end
      end
      for (int p = 0; p < NFIN; p++) begin
        if (fin_valid_i[p]) begin
          cq_r[fin_idx_i[p]].done <= 1'b1;
          cq_r[fin_idx_i[p]].exc  <= fin_exc_i[p];
        end
      end
      if (br_valid_i)
        cq_r[br_idx_i].done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // retirement queue pointers
  // ----------------------------------------------------------------
  // a fault empties the ring; a wrong branch cuts the tail back
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      head_r   <= '0;
      tail_r   <= '0;
      cq_cnt_r <= '0;
    end else if (exc_take) begin
      head_r   <= head_r + CW'(1);
      tail_r   <= head_r + CW'(1);
      cq_cnt_r <= '0;
    end else if (mispred) begin
      head_r   <= head_r + CW'(n_ret);
      tail_r   <= br_idx_i + CW'(1);
      cq_cnt_r <= (CW+1)'(int'(age_of(br_idx_i, head_r)) + 1 - n_ret);
    end else begin
      head_r   <= head_r + CW'(n_ret);
      tail_r   <= tail_r + CW'(n_disp);
      cq_cnt_r <= (CW+1)'(int'(cq_cnt_r) + n_disp - n_ret);
    end
  end

  // ----------------------------------------------------------------
  // rename pools
  // ----------------------------------------------------------------
  // take on dispatch, give back on retire and flush
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < NP; p++)
        ren_free_r[p] <= RW'(REN_DEPTH);
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (exc_take)
          ren_free_r[p] <= RW'(REN_DEPTH);
        else
          ren_free_r[p] <= RW'(int'(ren_free_r[p]) + rel[p] -
                               alloc[p]);
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // dispatch handed on one cycle after selection
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      disp_valid_o <= '0;
      disp_ins_o   <= '0;
      disp_idx_o   <= '0;
    end else begin
      disp_valid_o <= disp_go;
      for (int k = 0; k < DW; k++) begin
        disp_ins_o[k] <= hq_r[k];
        disp_idx_o[k] <= tail_r + CW'(k);
      end
    end
  end

  // retirement, fault and flush reports
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      retire_cnt_o <= '0;
      exc_o        <= 1'b0;
      exc_idx_o    <= '0;
      flush_o      <= 1'b0;
      flush_idx_o  <= '0;
    end else begin
      retire_cnt_o <= NRW'(n_ret);
      exc_o        <= exc_take;
      exc_idx_o    <= head_r;
      flush_o      <= flush_any;
      flush_idx_o  <= exc_take ? head_r : br_idx_i;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  int out_f;
  assign out_f = 32'($countones(disp_valid_o &
                 {disp_ins_o[2].unit == dcc_pkg::U_FLT,
                  disp_ins_o[1].unit == dcc_pkg::U_FLT,
                  disp_ins_o[0].unit == dcc_pkg::U_FLT}));

  // widened to int so a full queue does not wrap the bound
  property p_fetch_group;
    int'(hq_cnt_r) <= int'($past(hq_cnt_r)) + FW;
  endproperty
  a_fetch_group: assert property (p_fetch_group)
    else $error("holding queue grew by more than a fetch group");

  property p_hq_cap;
    (hq_cnt_r > HW'(HQ_DEPTH - FW)) |-> !fetch_ready_o ##1
      (hq_cnt_r <= HW'(HQ_DEPTH));
  endproperty
  a_hq_cap: assert property (p_hq_cap)
    else $error("fetch not stalled near full holding queue");

  property p_disp_window;
    disp_valid_o inside {3'h0, 3'h1, 3'h3, 3'h7};
  endproperty
  a_disp_window: assert property (p_disp_window)
    else $error("dispatch skipped a slot or exceeded three");

  property p_float_one;
    out_f <= dcc_pkg::FIQ_MAX;
  endproperty
  a_float_one: assert property (p_float_one)
    else $error("more than one float dispatch in a cycle");

  property p_cq_room;
    (cq_cnt_r == (CW+1)'(CQ_DEPTH)) |=> (disp_valid_o == '0);
  endproperty
  a_cq_room: assert property (p_cq_room)
    else $error("dispatch into a full retirement queue");

  property p_rename;
    (ren_free_r[0] == '0) |-> (alloc[0] == 0);
  endproperty
  a_rename: assert property (p_rename)
    else $error("integer rename taken from an empty pool");

  property p_in_order;
    (n_ret > 0 && !exc_take) |=>
      (head_r == $past(head_r) + CW'($past(n_ret))) &&
      (retire_cnt_o == $past(NRW'(n_ret)));
  endproperty
  a_in_order: assert property (p_in_order)
    else $error("head did not advance by the retired count");

  property p_branches;
    br_open <= BR_MAX;
  endproperty
  a_branches: assert property (p_branches)
    else $error("more than three open branches");

  property p_mispred;
    mispred |=> flush_o && (disp_valid_o == '0) &&
      (tail_r == $past(br_idx_i) + CW'(1)) && (hq_cnt_r == '0);
  endproperty
  a_mispred: assert property (p_mispred)
    else $error("wrong branch did not flush younger work");

  property p_precise;
    exc_take |=> exc_o && (retire_cnt_o == '0) && (cq_cnt_r == '0) &&
      (ren_free_r[0] == RW'(REN_DEPTH));
  endproperty
  a_precise: assert property (p_precise)
    else $error("fault not handled precisely");

  c_full_disp: cover property (disp_valid_o == 3'h7);
  c_full_ret: cover property (retire_cnt_o == NRW'(RTW));
  c_mispred: cover property (mispred ##1 flush_o);
  c_fault: cover property (exc_take ##1 exc_o);

endmodule

// ==== hw/dcc_pkg.sv ====
package dcc_pkg;

  // ----------------------------------------------------------------
  // sizes and limits
  // ----------------------------------------------------------------
  localparam int FETCH_W     = 4;  // fetched per cycle
  localparam int HQ_DEPTH    = 12; // holding queue slots
  localparam int DISP_W      = 3;  // dispatch window, slots zero..two
  localparam int FIQ_MAX     = 1;  // float issue accepts per cycle
  localparam int VIQ_MAX     = 2;  // vector issue accepts per cycle
  localparam int GIQ_MAX     = 3;  // general issue accepts per cycle
  localparam int CQ_DEPTH    = 16; // retirement queue entries
  localparam int RET_W       = 3;  // retired per cycle
  localparam int REN_DEPTH   = 16; // rename buffers per pool
  localparam int REN_POOLS   = 3;  // integer, float, vector
  localparam int BR_MAX      = 3;  // open speculative branches
  localparam int FIN_W       = 3;  // finish reports per cycle
  localparam int PIPE_STAGES = 7;  // stages through the core
  localparam int WORD_W      = 32; // instruction word width

  // ----------------------------------------------------------------
  // instruction word fields
  // ----------------------------------------------------------------
  localparam int UNIT_LSB = 30; // target issue queue
  localparam int DEST_LSB = 28; // destination register class
  localparam int BR_BIT   = 27; // branch marker

  // issue queue codes
  localparam logic [1:0] U_NONE = 2'h0; // retirement entry only
  localparam logic [1:0] U_GEN  = 2'h1;
  localparam logic [1:0] U_FLT  = 2'h2;
  localparam logic [1:0] U_VEC  = 2'h3;

  // destination class codes
  localparam logic [1:0] D_NONE = 2'h0;
  localparam logic [1:0] D_INT  = 2'h1; // integer_register
  localparam logic [1:0] D_FLT  = 2'h2; // float_register
  localparam logic [1:0] D_VEC  = 2'h3; // vector_register

  // decoded instruction
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [1:0]        unit;
    logic [1:0]        dest;
    logic              br;
  } dcc_ins_s;

  // retirement queue entry
  typedef struct packed {
    logic       done;
    logic       exc;
    logic       br;
    logic [1:0] dest;
  } dcc_cqe_s;

endpackage

// ==== hw/dcc_decode.sv ====
`timescale 1ns/1ns
module dcc_decode (
  input  wire logic [dcc_pkg::WORD_W-1:0] word_i, // raw fetched word
  output dcc_pkg::dcc_ins_s               ins_o   // fully decoded form
);

  logic [1:0] unit;
  logic [1:0] dest;
  logic       br;

  // field extraction
  assign unit = word_i[dcc_pkg::UNIT_LSB +: 2];
  assign dest = word_i[dcc_pkg::DEST_LSB +: 2];
  assign br   = word_i[dcc_pkg::BR_BIT];

  // branches take only a retirement entry and write no rename buffer
  always_comb begin
    ins_o.word = word_i;
    ins_o.br   = br;
    ins_o.unit = br ? dcc_pkg::U_NONE : unit;
    ins_o.dest = br ? dcc_pkg::D_NONE : dest;
  end

endmodule

// ==== tb/dcc_exec_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// issue queues and execution units, finishing one cycle after issue
// ----------------------------------------------------------------
module dcc_exec_model (
  input  wire logic                   ref_clk_i,   // core clock
  input  wire logic                   rstn_i,      // async reset
  input  wire logic [2:0]             disp_valid_i,// per slot
  input  dcc_pkg::dcc_ins_s [2:0]     disp_ins_i,  // decoded ins
  input  wire logic [2:0][3:0]        disp_idx_i,  // entry index
  input  wire logic                   flush_i,     // discard work
  output logic [2:0]                  fin_valid_o, // finish pulse
  output logic [2:0][3:0]             fin_idx_o,   // finished entry
  output logic [2:0]                  fin_exc_o    // fault on word bit 0
);
  // finish reports only for queued, non-branch work
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fin_valid_o <= '0;
      fin_idx_o   <= '0;
      fin_exc_o   <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        fin_valid_o[k] <= disp_valid_i[k] & ~flush_i &
          (disp_ins_i[k].unit != dcc_pkg::U_NONE) & ~disp_ins_i[k].br;
        fin_idx_o[k] <= disp_valid_i[k] ? disp_idx_i[k] : ~fin_idx_o[k];
        fin_exc_o[k] <= disp_ins_i[k].word[0]; // bench fault marker
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic clk, rstn, brv, brm, fr, fl, ex;
  logic [2:0] cnt, dv, fv, fe;
  logic [3:0][31:0] wd;
  dcc_pkg::dcc_ins_s [2:0] di;
  logic [2:0][3:0] dx, fx;
  logic [3:0] bx, fli, exi, brs, fsx, exs;
  logic [1:0] rc;
  int mismatches, compares, cyc, ret, mxd, mxf, nd, nf, nfl, nex;
  // ----------------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  dcc_top uut (.ref_clk_i(clk), .rstn_i(rstn), .fetch_cnt_i(cnt),
    .fetch_word_i(wd), .fetch_ready_o(fr), .fiq_room_i(2'h1),
    .viq_room_i(2'h2), .giq_room_i(2'h3), .disp_valid_o(dv),
    .disp_ins_o(di), .disp_idx_o(dx), .fin_valid_i(fv), .fin_idx_i(fx),
    .fin_exc_i(fe), .br_valid_i(brv), .br_idx_i(bx),
    .br_mispred_i(brm), .retire_cnt_o(rc), .exc_o(ex),
    .exc_idx_o(exi), .flush_o(fl), .flush_idx_o(fli));
  dcc_exec_model part (.ref_clk_i(clk), .rstn_i(rstn), .disp_valid_i(dv),
    .disp_ins_i(di), .disp_idx_i(dx), .flush_i(fl), .fin_valid_o(fv),
    .fin_idx_o(fx), .fin_exc_o(fe));
  // monitor of dispatch, retirement and flush, on settled outputs
  always @(negedge clk) begin
    cyc++;
    ret += rc;
    nd = 0;
    nf = 0;
    for (int k = 0; k < 3; k++) begin
      nd += dv[k];
      nf += dv[k] & (di[k].unit == dcc_pkg::U_FLT);
      if (dv[k] & di[k].br) brs = dx[k];
    end
    if (nd > mxd) mxd = nd;
    if (nf > mxf) mxf = nf;
    if (fl === 1'b1) begin
      nfl++;
      fsx = fli;
    end
    if (ex === 1'b1) begin
      nex++;
      exs = exi;
    end
    if (cyc > 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // offer a group once fetch has room, then idle
  task automatic fetch(input logic [2:0] n, input logic [3:0][31:0] w);
    for (int i = 0; i < 50 && fr !== 1'b1; i++) @(negedge clk);
    cnt = n;
    wd = w;
    @(negedge clk);
    cnt = 3'h0;
    repeat (12) @(negedge clk);
  endtask
  task automatic clr();
    ret = 0;
    mxd = 0;
    mxf = 0;
    nfl = 0;
    nex = 0;
  endtask
  // four general ops: three at most per cycle, all retire in order
  task automatic t_gen();
    clr();
    fetch(3'h4, {4{32'h4000_0000}});
    check(8'(mxd), 8'h03);
    check(8'(ret), 8'h04);
    $display("test general done");
  endtask
  // three float ops: float queue takes one per cycle
  task automatic t_flt();
    clr();
    fetch(3'h3, {4{32'h8000_0000}});
    check(8'(mxf), 8'h01);
    check(8'(ret), 8'h03);
    $display("test float done");
  endtask
  // branch then two general ops, branch mispredicts
  task automatic t_br();
    clr();
    fetch(3'h3, {32'h0, 32'h4000_0000, 32'h4000_0000, 32'h0800_0000});
    check(8'(brs), 8'h07);
    bx = 4'h7;
    brv = 1;
    brm = 1;
    @(negedge clk);
    brv = 0;
    brm = 0;
    repeat (10) @(negedge clk);
    check(8'(nfl), 8'h01);
    check(8'(fsx), 8'h07);
    check(8'(ret), 8'h01);
    $display("test mispredict done");
  endtask
  // middle of three general ops faults: older retires, rest dropped
  task automatic t_exc();
    clr();
    fetch(3'h3, {32'h0, 32'h4000_0000, 32'h4000_0001, 32'h4000_0000});
    check(8'(ret), 8'h01);
    check(8'(nex), 8'h01);
    check(8'(exs), 8'h09);
    check(8'(fsx), 8'h09);
    $display("test fault done");
  endtask
  // back to back float groups: fetch must stall near full
  task automatic t_stall();
    clr();
    cnt = 3'h4;
    wd = {4{32'h8000_0000}};
    repeat (4) @(negedge clk);
    cnt = 3'h0;
    repeat (20) @(negedge clk);
    check(8'(ret), 8'h0c);
    check(8'(mxf), 8'h01);
    $display("test stall done");
  endtask
  // reset in mid-run drops queued work and reopens fetch
  task automatic t_rst();
    clr();
    cnt = 3'h3;
    wd = {4{32'h4000_0000}};
    @(negedge clk);
    cnt = 3'h0;
    rstn = 0;
    @(negedge clk);
    check(8'({fr, dv, rc}), 8'h00);
    rstn = 1;
    @(negedge clk);
    check(8'(fr), 8'h01);
    repeat (12) @(negedge clk);
    check(8'(ret), 8'h00);
    check(8'(mxd), 8'h00);
    $display("test reset done");
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rstn = 0;
    cnt = 3'h0;
    wd = '0;
    brv = 0;
    brm = 0;
    bx = 4'h0;
    brs = 4'h0;
    repeat (6) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    t_gen();
    t_flt();
    t_br();
    t_exc();
    t_stall();
    t_rst();
    summarize();
  end
endmodule
